// file: rtl/led_pkg.sv
// constants, types and register map of the status LED and reset contact timer
package led_pkg;
	// clock rate in kHz, so that cycle counts stay inside 32 bits
	localparam int CLK_KHZ = 50000;

	// times in milliseconds as specified
	localparam int BLINK_HALF_MS = 50;
	localparam int MIN_PRESS_MS = 500;
	localparam int DEFIP_MAX_MS = 2000;
	localparam int FACTORY_MS = 10000;
	localparam int FLASH_IVL_MS = 500;
	localparam int GAP_MS = 4000;
	localparam int DEBOUNCE_MS = 10;

	// derived cycle counts
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
	localparam int MIN_PRESS_CYC = MIN_PRESS_MS * CLK_KHZ;
	localparam int DEFIP_MAX_CYC = DEFIP_MAX_MS * CLK_KHZ;
	localparam int FACTORY_CYC = FACTORY_MS * CLK_KHZ;
	localparam int FLASH_IVL_CYC = FLASH_IVL_MS * CLK_KHZ;
	localparam int FLASH_ON_CYC = FLASH_IVL_CYC / 2;
	localparam int GAP_CYC = GAP_MS * CLK_KHZ;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK = 8'h08;
	localparam logic [7:0] ADDR_MODE = 8'h0C;
	localparam logic [7:0] ADDR_HOLD = 8'h10;

	// system states shown in status mode
	typedef enum logic [2:0] {
		SYS_STARTING = 3'h0,
		SYS_NO_NET = 3'h1,
		SYS_NORMAL = 3'h2,
		SYS_DEFIP = 3'h3,
		SYS_FACTORY = 3'h4
	} sys_state_e;

	localparam sys_state_e CTRL_RESET = SYS_STARTING;
	localparam logic [4:0] MASK_RESET = 5'h00;

	// contact sequencer states
	typedef enum logic [3:0] {
		ST_STATUS = 4'h1,
		ST_FAST = 4'h2,
		ST_HOLD = 4'h4,
		ST_FACT = 4'h8
	} seq_state_e;

	// event bits, same layout in status and mask registers
	typedef struct packed {
		logic restart;
		logic factory;
		logic defip;
		logic spurious;
		logic press;
	} evt_s;

	// number of flashes per pattern; zero means solid on
	function automatic logic [2:0] flash_count(input sys_state_e s);
		case (s)
			SYS_NO_NET: flash_count = 3'h1;
			SYS_NORMAL: flash_count = 3'h2;
			SYS_DEFIP: flash_count = 3'h3;
			SYS_FACTORY: flash_count = 3'h3;
			default: flash_count = 3'h0;
		endcase
	endfunction : flash_count
endpackage : led_pkg

// file: rtl/contact_debounce.sv
// two-stage synchroniser and debouncer for the reset contact pair
`timescale 1ns/1ps
module contact_debounce #(
	parameter int STABLE_CYC = led_pkg::DEBOUNCE_CYC
) (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire logic raw, // contact level from the pin
	output logic level // debounced level
);
	logic sync1_q;
	logic sync2_q;
	logic [31:0] cnt_q;
	logic level_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
		end
	end

	// bounce restarts only this filter, never the bridge timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0;
			level_q <= 1'b0;
		end else if (sync2_q == level_q) begin
			cnt_q <= 32'h0;
		end else if (cnt_q >= 32'(STABLE_CYC - 1)) begin
			cnt_q <= 32'h0;
			level_q <= sync2_q;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

	assign level = level_q;
endmodule : contact_debounce

// file: rtl/status_led_reset_contact_timer.sv
// status LED sequencer and reset contact press classifier with APB registers
//
// Contract
// - contacts bridged enters settings mode, LED blinks at 10 Hz.
// - release after 0.5 to 2 s requests the default address.
// - from 2 to 10 s LED steady, release does nothing.
// - at 10 s bridged the LED blinks again.
// - release after 10 s requests factory restore plus secondary default address.
// - leaving settings mode returns the LED to status patterns.
// - status: N flashes 0.5 s apart, 4 s dark, repeated.
// - while starting, LED solid on.
// - one flash when running without network.
// - two flashes for normal operation.
// - three flashes after the default address was applied.
// - three flashes after factory restore, restart requested on release.
`timescale 1ns/1ps
module status_led_reset_contact_timer #(
	parameter int BLINK_HALF_CYC = led_pkg::BLINK_HALF_CYC,
	parameter int MIN_PRESS_CYC = led_pkg::MIN_PRESS_CYC,
	// the default-address limit and flash interval scale from the minimum press, so a shortened timebase keeps the documented ratios
	parameter int DEFIP_MAX_CYC = MIN_PRESS_CYC * (led_pkg::DEFIP_MAX_MS / led_pkg::MIN_PRESS_MS),
	parameter int FACTORY_CYC = led_pkg::FACTORY_CYC,
	parameter int FLASH_IVL_CYC = MIN_PRESS_CYC * (led_pkg::FLASH_IVL_MS / led_pkg::MIN_PRESS_MS),
	parameter int FLASH_ON_CYC = FLASH_IVL_CYC / 2,
	parameter int GAP_CYC = led_pkg::GAP_CYC,
	parameter int DEBOUNCE_CYC = led_pkg::DEBOUNCE_CYC
) (
	input wire logic pclk, // clock, 50 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic contact_bridged, // raw contact pair, high while bridged
	output logic led, // indicator LED, high lit
	output logic defip_req, // pulse: load default address
	output logic factory_req, // pulse: factory restore plus secondary address
	output logic restart_req, // pulse: full system restart
	output logic irq // level interrupt
);
	logic bridged;
	logic bridged_q;
	logic [31:0] hold_q;
	led_pkg::seq_state_e state_q;
	led_pkg::seq_state_e state_d;
	led_pkg::sys_state_e sys_q;
	led_pkg::evt_s status_q;
	led_pkg::evt_s mask_q;
	logic [31:0] blink_cnt_q;
	logic blink_q;
	logic [31:0] pat_cnt_q;
	logic [2:0] pat_idx_q;
	logic pat_gap_q;
	logic led_q;
	logic defip_req_q;
	logic factory_req_q;
	logic restart_req_q;
	logic irq_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// terminal count test shared by the blink, hold and pattern timers
	function automatic logic reached(input logic [31:0] cnt, input int lim);
		reached = (cnt >= 32'(lim - 1));
	endfunction : reached

	wire blink_wrap = reached(blink_cnt_q, BLINK_HALF_CYC);
	wire fast_done = reached(hold_q, DEFIP_MAX_CYC);
	wire hold_done = reached(hold_q, FACTORY_CYC);

	contact_debounce #(
		.STABLE_CYC(DEBOUNCE_CYC)
	) u_debounce (
		.pclk(pclk),
		.presetn(presetn),
		.raw(contact_bridged),
		.level(bridged)
	);

	// contact edges and release classification
	wire press_rise = bridged & ~bridged_q;
	wire press_fall = ~bridged & bridged_q;
	wire in_fast = (state_q == led_pkg::ST_FAST);
	wire in_hold = (state_q == led_pkg::ST_HOLD);
	wire in_fact = (state_q == led_pkg::ST_FACT);
	wire in_status = (state_q == led_pkg::ST_STATUS);
	// judged on the count at the debounced release, so a short dropout cannot split a press
	wire long_enough = (hold_q >= 32'(MIN_PRESS_CYC));
	wire evt_spurious = press_fall & in_fast & ~long_enough;
	wire evt_defip = press_fall & in_fast & long_enough;
	wire evt_factory = press_fall & in_fact;
	wire evt_restart = press_fall & in_fact;

	led_pkg::evt_s evt;
	assign evt.restart = evt_restart;
	assign evt.factory = evt_factory;
	assign evt.defip = evt_defip;
	assign evt.spurious = evt_spurious;
	assign evt.press = press_rise;

	// apb decode
	wire setup = psel & ~penable;
	wire hit_ctrl = (paddr == led_pkg::ADDR_CTRL);
	wire hit_status = (paddr == led_pkg::ADDR_STATUS);
	wire hit_mask = (paddr == led_pkg::ADDR_MASK);
	wire hit_mode = (paddr == led_pkg::ADDR_MODE);
	wire hit_hold = (paddr == led_pkg::ADDR_HOLD);
	wire hit = hit_ctrl | hit_status | hit_mask | hit_mode | hit_hold;
	wire wr_en = psel & penable & pready_q & pwrite & hit;
	wire wr_ctrl = wr_en & hit_ctrl;
	wire wr_status = wr_en & hit_status;
	wire wr_mask = wr_en & hit_mask;
	// read-only view: sequencer phase, filtered contact and settings flag
	wire settings_mode = ~in_status;
	wire [31:0] mode_word = {26'h0, state_q, bridged, settings_mode};
	wire [31:0] rd_data =
		hit_ctrl ? {29'h0, sys_q} :
		hit_status ? {27'h0, status_q} :
		hit_mask ? {27'h0, mask_q} :
		hit_mode ? mode_word :
		hit_hold ? hold_q : 32'h0;

	// sequencer next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			led_pkg::ST_STATUS: begin
				if (press_rise) begin
					state_d = led_pkg::ST_FAST;
				end
			end
			led_pkg::ST_FAST: begin
				if (press_fall) begin
					state_d = led_pkg::ST_STATUS;
				end else if (fast_done) begin
					state_d = led_pkg::ST_HOLD;
				end
			end
			led_pkg::ST_HOLD: begin
				if (press_fall) begin
					state_d = led_pkg::ST_STATUS;
				end else if (hold_done) begin
					state_d = led_pkg::ST_FACT;
				end
			end
			led_pkg::ST_FACT: begin
				if (press_fall) begin
					state_d = led_pkg::ST_STATUS;
				end
			end
			default: state_d = led_pkg::ST_STATUS;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= led_pkg::ST_STATUS;
			bridged_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bridged_q <= bridged;
		end
	end

	// bridge duration, saturating so a very long press stays in the factory phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= 32'h0;
		end else if (!bridged) begin
			hold_q <= 32'h0;
		end else if (hold_q != 32'hFFFFFFFF) begin
			hold_q <= hold_q + 32'h1;
		end
	end

	// 10 Hz blink, restarted lit at each press
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b1;
		end else if (press_rise) begin
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b1;
		end else if (blink_wrap) begin
			blink_cnt_q <= 32'h0;
			blink_q <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h1;
		end
	end

	// system state: firmware writes it, a press outcome overrides in the same cycle
	// codes above the factory code are kept as written and show solid on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_q <= led_pkg::CTRL_RESET;
		end else if (evt_factory) begin
			sys_q <= led_pkg::SYS_FACTORY;
		end else if (evt_defip) begin
			sys_q <= led_pkg::SYS_DEFIP;
		end else if (wr_ctrl) begin
			sys_q <= led_pkg::sys_state_e'(pwdata[2:0]);
		end
	end

	// status pattern; restarts from the first flash whenever settings mode ends
	wire [2:0] n_flash = led_pkg::flash_count(sys_q);
	wire pat_run = in_status & (n_flash != 3'h0);
	// pattern counter end points
	wire gap_done = reached(pat_cnt_q, GAP_CYC);
	wire flash_done = reached(pat_cnt_q, FLASH_IVL_CYC);
	wire last_flash = (pat_idx_q >= n_flash - 3'h1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pat_cnt_q <= 32'h0;
			pat_idx_q <= 3'h0;
			pat_gap_q <= 1'b0;
		end else if (!pat_run) begin
			pat_cnt_q <= 32'h0;
			pat_idx_q <= 3'h0;
			pat_gap_q <= 1'b0;
		end else if (pat_gap_q) begin
			if (gap_done) begin
				pat_cnt_q <= 32'h0;
				pat_idx_q <= 3'h0;
				pat_gap_q <= 1'b0;
			end else begin
				pat_cnt_q <= pat_cnt_q + 32'h1;
			end
		end else if (flash_done) begin
			pat_cnt_q <= 32'h0;
			if (last_flash) begin
				pat_gap_q <= 1'b1;
			end else begin
				pat_idx_q <= pat_idx_q + 3'h1;
			end
		end else begin
			pat_cnt_q <= pat_cnt_q + 32'h1;
		end
	end

	// each flash is lit for the first part of its interval, then dark until the next
	wire flash_on = ~pat_gap_q & (pat_cnt_q < 32'(FLASH_ON_CYC));
	wire status_led = (n_flash == 3'h0) ? 1'b1 : flash_on;
	// settings phases take the LED over from the status pattern while bridged
	wire led_d = in_status ? status_led :
		in_hold ? 1'b1 :
		blink_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_q <= 1'b1;
			defip_req_q <= 1'b0;
			factory_req_q <= 1'b0;
			restart_req_q <= 1'b0;
		end else begin
			led_q <= led_d;
			defip_req_q <= evt_defip;
			factory_req_q <= evt_factory;
			restart_req_q <= evt_restart;
		end
	end

	// interrupt status: a new event wins over a write-one clear in the same cycle
	wire [4:0] clr_bits = wr_status ? pwdata[4:0] : 5'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= '0;
			mask_q <= led_pkg::MASK_RESET;
			irq_q <= 1'b0;
		end else begin
			status_q <= (status_q & ~clr_bits) | evt;
			if (wr_mask) begin
				mask_q <= pwdata[4:0];
			end
			irq_q <= |(status_q & mask_q);
		end
	end

	// apb slave: one wait-free access cycle, data and ready registered in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~hit;
			prdata_q <= (setup & ~pwrite) ? rd_data : 32'h0;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign led = led_q;
	assign defip_req = defip_req_q;
	assign factory_req = factory_req_q;
	assign restart_req = restart_req_q;
	assign irq = irq_q;
endmodule : status_led_reset_contact_timer

// file: verification/status_led_reset_contact_timer_monitor.sv
// port checker for the status LED and contact timer
`timescale 1ns/1ps
module status_led_reset_contact_timer_monitor (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic contact_bridged, // raw contacts
	input wire logic defip_req, // default address request
	input wire logic factory_req, // factory request
	input wire logic restart_req // restart request
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
	a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
	a_error_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
	a_restart_with_factory: assert property (factory_req == restart_req) else $error("restart unpaired");
	a_defip_pulse: assert property (defip_req |=> !defip_req) else $error("long defip");
	a_factory_pulse: assert property (factory_req |=> !factory_req [*8]) else $error("repeat factory");
	a_single_outcome: assert property (!(defip_req && factory_req)) else $error("two outcomes");
	a_req_after_release: assert property (defip_req || factory_req |-> $past(contact_bridged, 2) == 1'b0)
		else $error("request while bridged");
	c_defip: cover property (defip_req);
	c_factory: cover property (factory_req);
	c_error: cover property (pslverr);
endmodule : status_led_reset_contact_timer_monitor

bind status_led_reset_contact_timer status_led_reset_contact_timer_monitor mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.contact_bridged(contact_bridged), .defip_req(defip_req), .factory_req(factory_req), .restart_req(restart_req));

// file: verification/contact_pair.sv
// reset contact pair model with bounce
`timescale 1ns/1ps
module contact_pair (
	input wire logic pclk, // clock
	input wire logic go, // start a press
	input wire logic [31:0] hold_cyc, // press length
	output logic pin, // high while bridged
	output logic busy // press running
);
	int cnt = 0;
	initial begin
		pin = 1'b0;
		busy = 1'b0;
	end
	// bounce at make and a dropout mid-press, both shorter than the debounce window
	always @(posedge pclk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			cnt <= 0;
		end else if (busy) begin
			cnt <= cnt + 1;
			busy <= cnt < hold_cyc + 4;
		end
		pin <= busy && cnt < hold_cyc && cnt != 1 && cnt != hold_cyc / 2;
	end
endmodule : contact_pair

// file: verification/test_status_led_reset_contact_timer.sv
// self-checking bench for the status LED and contact timer
`timescale 1ns/1ps
module test_status_led_reset_contact_timer;
	logic pclk, presetn, psel, penable, pwrite, go, pready, pslverr, pin, busy, led, dreq, freq, rreq, irq, err, m;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed_q;
	int hold, k, h, cur, error_cnt = 0, n_tests = 0;
	int lo[4] = '{10, 30, 182, 265};
	int sp[4] = '{6, 42, 13, 55};
	int hv[4] = '{12, 24, 190, 262};
	// default-address limit and flash timing follow from the minimum press inside the design
	status_led_reset_contact_timer #(.BLINK_HALF_CYC(4), .MIN_PRESS_CYC(20), .FACTORY_CYC(200), .GAP_CYC(60),
		.DEBOUNCE_CYC(3)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .contact_bridged(pin), .led(led), .defip_req(dreq),
		.factory_req(freq), .restart_req(rreq), .irq(irq));
	contact_pair model (.pclk(pclk), .go(go), .hold_cyc(hold), .pin(pin), .busy(busy));
	function automatic int exp_n(input int s);
		return (s > 3) ? 3 : s;
	endfunction : exp_n
	task finish_test;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task check(input logic [31:0] got, input logic [31:0] exp, input string s);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %0h", $time, s, got);
		end
	endtask : check
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task pat(input int n);
		int per, rs, lit;
		logic p;
		per = (n == 0) ? 100 : n * 20 + 60;
		rs = 0;
		lit = 0;
		repeat (140) @(posedge pclk);
		p = led;
		repeat (per) begin
			@(posedge pclk);
			rs += led && !p;
			lit += led;
			p = led;
		end
		check(rs, n, "flashes");
		check(lit, (n == 0) ? per : n * 10, "lit");
	endtask : pat
	task press;
		int r1, r2, lit, nd, nf, nr;
		logic p;
		{r1, r2, lit, nd, nf, nr} = 0;
		hold <= h;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		p = led;
		for (int t = 1; t < h + 40; t++) begin
			@(posedge pclk);
			r1 += t >= 16 && t < 56 && led && !p;
			lit += t >= 100 && t < 180 && led;
			r2 += t >= 220 && t < 260 && led && !p;
			nd += dreq;
			nf += freq;
			nr += rreq;
			p = led;
		end
		if (k >= 2) check(r1, 5, "fast blink");
		if (k >= 2) check(lit, 80, "steady");
		if (k == 3) check(r2, 5, "blink again");
		check(nd, k == 1, "defip");
		check(nf, k == 3, "factory");
		check(nr, k == 3, "restart");
		apb(0, 8'h04, 32'h0);
		check(rd, {27'h0, k == 3, k == 3, k == 1, k == 0, 1'b1}, "events");
		check(irq, m, "irq");
		apb(1, 8'h04, 32'h1F);
		repeat (2) @(posedge pclk);
		check(irq, 0, "irq clear");
		cur = (k == 1) ? 3 : (k == 3) ? 4 : cur;
		apb(0, 8'h00, 32'h0);
		check(rd, cur, "state");
		pat(exp_n(cur));
	endtask : press
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		repeat (60000) @(posedge pclk);
		error_cnt++;
		finish_test;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, go, hold, m} = 0;
		seed_q = $urandom(18402);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		check(led, 1, "reset led");
		apb(0, 8'h08, 32'h0);
		check(rd, 32'h0, "mask reset");
		apb(0, 8'h0C, 32'h0);
		check(rd, 32'h4, "mode idle");
		apb(0, 8'h10, 32'h0);
		check(rd, 32'h0, "hold idle");
		apb(0, 8'h14, 32'h0);
		check({rd[30:0], err}, 32'h1, "unmapped");
		pat(0);
		for (int s = 1; s < 5; s++) begin
			apb(1, 8'h00, s);
			pat(exp_n(s));
		end
		cur = $urandom_range(1, 2);
		apb(1, 8'h00, cur);
		for (int i = 0; i < 8; i++) begin
			k = i % 4;
			h = (i < 4) ? hv[k] : lo[k] + $urandom_range(0, sp[k]);
			if (i == 1) apb(1, 8'h08, 32'h1F);
			m = i > 0;
			press;
		end
		finish_test;
	end
endmodule : test_status_led_reset_contact_timer
